// ==== lcr_link_cap.sv ====
`timescale 1ns/1ps
`include "lcr_map.svh"
// Summary of operation
// - Bits 3:0 hold the supported link speed, 1 for 2.5 Gbps, 2 for 5 Gbps, reset value 0x1.
// - Bits 9:4 hold the maximum link width, valid codes 1, 2, 4, 8, 12, 16 and 32.
// - A reserved or invalid width code makes the link train as a single lane.
// - The width field starts at the physical port width and software may lower it.
// - Bits 11:10 are read-only 0x3, both low-power link states supported.
// - Bits 14:12 read 0x5 with separate reference clocks and 0x3 with a common clock.
// - Bits 17:15 give the deep low-power exit latency, reset value 0x2.
// - Bit 18 resets to 0, reference clock removal not tolerated.
// - Bit 19, surprise-down reporting, defaults to 0 upstream and 1 downstream.
// - Bit 20, link-active reporting, defaults to 1 downstream and stays 0 upstream.
// - Bit 21, bandwidth notification, defaults to 1 downstream and stays 0 upstream.
// - In the older revision mode bit 21 defaults to 0 on every port.
// - Bits 31:24 return the port number, read-only.
// - The common clock control bit selects the common-clock latency code.
module lcr_link_cap (
   input  wire logic        ref_clk,        // Configuration clock
   input  wire logic        rst_n,          // Synchronous reset, active low
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB access phase
   input  wire logic        pwrite,         // APB write
   input  wire logic [11:0] paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   output logic      [31:0] prdata,         // APB read data
   output logic             pready,         // APB ready
   output logic             pslverr,        // APB error
   input  wire logic        upstream_pin,   // Strap: port is upstream
   input  wire logic        legacy_rev_pin, // Strap: older revision mode
   input  wire logic  [5:0] phys_width_pin, // Strap: physical lane count
   input  wire logic  [7:0] port_num_pin,   // Strap: port number
   output logic       [3:0] link_speed,     // Speed code used for training
   output logic       [5:0] train_width,    // Lane count used for training
   output logic             common_clock    // Common clock configuration
);
   import lcr_pkg::*;

   lcr_regs_t r_reg;
   lcr_regs_t r_next;

   logic        up_s;
   logic        legacy_s;
   logic [5:0]  phys_s;
   logic [7:0]  port_number_field_s;
   logic        setup;
   logic        access;
   logic        hit_cap;
   logic        hit_ctrl;
   logic [5:0]  wr_width;
   logic [31:0] cap_word;
   logic [31:0] ctrl_word;

   // Settled strap values, read only from the second stage
   assign up_s      = r_reg.strap_sync[15];
   assign legacy_s  = r_reg.strap_sync[14];
   assign phys_s    = r_reg.strap_sync[13:8];
   assign port_number_field_s = r_reg.strap_sync[7:0];

   // Bus phase decode; no answer until defaults are loaded
   assign setup    = psel & ~penable;
   assign access   = psel & penable & (r_reg.state == LCR_RUN);
   assign hit_cap  = (paddr == `LCR_LINK_CAP_ADDR);
   assign hit_ctrl = (paddr == `LCR_CAP_CTRL_ADDR);
   assign wr_width = pwdata[`LCR_WIDTH_LSB +: 6];

   // Width check: reserved codes fall back to one lane
   function automatic logic width_valid(input logic [5:0] w);
      width_valid = (w == 6'h01) || (w == 6'h02) || (w == 6'h04) ||
                    (w == 6'h08) || (w == 6'h0C) || (w == 6'h10) ||
                    (w == 6'h20);
   endfunction : width_valid

   // Assembled capability word
   always_comb begin
      cap_word = 32'h0000_0000;
      cap_word[`LCR_SPEED_LSB +: 4]   = r_reg.speed;
      cap_word[`LCR_WIDTH_LSB +: 6]   = r_reg.width;
      cap_word[`LCR_LOWPWR_LSB +: 2]  = `LCR_LOWPWR_VAL;
      cap_word[`LCR_SHALLOW_LSB +: 3] = r_reg.com_clk ? `LCR_SHALLOW_COM
                                                   : `LCR_SHALLOW_SEP;
      cap_word[`LCR_DEEP_LSB +: 3]    = r_reg.deep_lat;
      cap_word[`LCR_REFCLK_BIT]       = r_reg.refclk_rm;
      cap_word[`LCR_SDOWN_BIT]        = r_reg.sdown;
      cap_word[`LCR_DLACT_BIT]        = r_reg.dl_active;
      cap_word[`LCR_BWN_BIT]          = r_reg.bw_notify;
      cap_word[`LCR_PORT_NUMBER_FIELD_LSB +: 8] = port_number_field_s;
   end

   // Control word
   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[`LCR_COMCLK_BIT] = r_reg.com_clk;
      ctrl_word[`LCR_UNLOCK_BIT] = r_reg.unlock;
   end

   // Next state
   always_comb begin
      r_next = r_reg;
      r_next.strap_meta = {upstream_pin, legacy_rev_pin, phys_width_pin, port_num_pin};
      r_next.strap_sync = r_reg.strap_meta;
      unique case (r_reg.state)
         LCR_INIT: begin
            // Wait for the straps to clear the synchroniser
            if (r_reg.init_cnt == `LCR_INIT_CYCLES) begin
               r_next.state     = LCR_RUN;
               r_next.width     = phys_s;
               r_next.sdown     = ~up_s;
               r_next.dl_active = ~up_s;
               r_next.bw_notify = ~up_s & ~legacy_s;
            end else begin
               r_next.init_cnt = r_reg.init_cnt + 2'h1;
            end
         end
         LCR_RUN: begin
            // Read data latched in setup, held through access
            if (setup) begin
               r_next.prdata  = hit_cap ? cap_word : (hit_ctrl ? ctrl_word : 32'h0000_0000);
               r_next.pslverr = ~(hit_cap | hit_ctrl);
            end
            if (access && pwrite && hit_cap && r_reg.unlock) begin
               r_next.speed     = pwdata[`LCR_SPEED_LSB +: 4];
               r_next.width     = wr_width;
               r_next.deep_lat  = pwdata[`LCR_DEEP_LSB +: 3];
               r_next.refclk_rm = pwdata[`LCR_REFCLK_BIT];
               r_next.sdown     = pwdata[`LCR_SDOWN_BIT];
               // Upstream port never advertises these two
               r_next.dl_active = pwdata[`LCR_DLACT_BIT] & ~up_s;
               r_next.bw_notify = pwdata[`LCR_BWN_BIT] & ~up_s;
            end
            if (access && pwrite && hit_ctrl) begin
               r_next.com_clk = pwdata[`LCR_COMCLK_BIT];
               r_next.unlock = pwdata[`LCR_UNLOCK_BIT];
            end
         end
      endcase
   end

   // State register; reset loads constants only, straps come later
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         r_reg.state      <= LCR_INIT;
         r_reg.init_cnt   <= 2'h0;
         r_reg.strap_meta <= 16'h0000;
         r_reg.strap_sync <= 16'h0000;
         r_reg.speed      <= `LCR_SPEED_RST;
         r_reg.width      <= `LCR_WIDTH_X1;
         r_reg.deep_lat   <= `LCR_DEEP_RST;
         r_reg.refclk_rm  <= `LCR_REFCLK_RST;
         r_reg.sdown      <= 1'b0;
         r_reg.dl_active  <= 1'b0;
         r_reg.bw_notify  <= 1'b0;
         r_reg.com_clk    <= 1'b0;
         r_reg.unlock     <= 1'b0;
         r_reg.prdata     <= 32'h0000_0000;
         r_reg.pslverr    <= 1'b0;
      end else begin
         r_reg <= r_next;
      end
   end

   // Bus outputs
   assign pready  = access;
   assign prdata  = r_reg.prdata;
   assign pslverr = access & r_reg.pslverr;

   // Training controls; a bad code or a widening write is clamped
   assign link_speed   = r_reg.speed;
   assign common_clock = r_reg.com_clk;
   assign train_width  = !width_valid(r_reg.width) ? `LCR_WIDTH_X1 :
                         (r_reg.width > phys_s) ? phys_s : r_reg.width;

endmodule : lcr_link_cap

// ==== lcr_map.svh ====
`ifndef LCR_MAP_SVH
`define LCR_MAP_SVH

// Register byte addresses
`define LCR_LINK_CAP_ADDR    12'h04C
`define LCR_CAP_CTRL_ADDR    12'h080

// Link capabilities field positions
`define LCR_SPEED_LSB        0
`define LCR_WIDTH_LSB        4
`define LCR_LOWPWR_LSB       10
`define LCR_SHALLOW_LSB      12
`define LCR_DEEP_LSB         15
`define LCR_REFCLK_BIT       18
`define LCR_SDOWN_BIT        19
`define LCR_DLACT_BIT        20
`define LCR_BWN_BIT          21
`define LCR_PORT_NUMBER_FIELD_LSB      24

// Control register bit positions
`define LCR_COMCLK_BIT       0
`define LCR_UNLOCK_BIT       1

// Reset and fixed values
`define LCR_SPEED_RST        4'h1
`define LCR_LOWPWR_VAL       2'h3
`define LCR_SHALLOW_SEP      3'h5
`define LCR_SHALLOW_COM      3'h3
`define LCR_DEEP_RST         3'h2
`define LCR_REFCLK_RST       1'h0
`define LCR_WIDTH_X1         6'h01

// Strap settling: synchroniser depth before defaults load
`define LCR_INIT_CYCLES      2'h2

`endif

// ==== lcr_pkg.sv ====
package lcr_pkg;

   // Power-up sequence
   typedef enum logic [0:0] {
      LCR_INIT = 1'b0,
      LCR_RUN  = 1'b1
   } lcr_state_t;

   // Whole register state of the block
   typedef struct packed {
      lcr_state_t  state;
      logic [1:0]  init_cnt;
      logic [15:0] strap_meta;   // first sync stage
      logic [15:0] strap_sync;   // second sync stage
      logic [3:0]  speed;
      logic [5:0]  width;
      logic [2:0]  deep_lat;
      logic        refclk_rm;
      logic        sdown;
      logic        dl_active;
      logic        bw_notify;
      logic        com_clk;
      logic        unlock;
      logic [31:0] prdata;
      logic        pslverr;
   } lcr_regs_t;

endpackage : lcr_pkg

// ==== lcr_link_cap_properties.sv ====
`timescale 1ns/1ps
module lcr_link_cap_properties (
   input wire logic        ref_clk,        // Clock
   input wire logic        rst_n,          // Reset
   input wire logic        psel,           // Select
   input wire logic        penable,        // Access
   input wire logic        pwrite,         // Write
   input wire logic [11:0] paddr,          // Address
   input wire logic [31:0] pwdata,         // Wdata
   input wire logic [31:0] prdata,         // Rdata
   input wire logic        pready,         // Ready
   input wire logic        pslverr,        // Error
   input wire logic        upstream_pin,   // Strap
   input wire logic        legacy_rev_pin, // Strap
   input wire logic [5:0]  phys_width_pin, // Strap
   input wire logic [7:0]  port_num_pin,   // Strap
   input wire logic [3:0]  link_speed,     // Speed
   input wire logic [5:0]  train_width,    // Width
   input wire logic        common_clock    // Mode
);
   import lcr_pkg::*;
   // Completed access, and completed read of the capabilities word
   logic acc;
   logic rd;
   logic [5:0] wf;
   assign acc = psel && penable && pready;
   assign rd = acc && !pwrite && paddr == 12'h04C;
   assign wf = prdata[9:4];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_ro; rd |-> prdata[11:10] == 2'h3 && prdata[23:22] == 2'h0; endproperty
   a_ro: assert property (p_ro) else $error("fixed bits wrong");
   property p_lat; rd |-> prdata[14:12] == (common_clock ? 3'h3 : 3'h5); endproperty
   a_lat: assert property (p_lat) else $error("exit latency wrong");
   property p_port; rd |-> prdata[31:24] == port_num_pin; endproperty
   a_port: assert property (p_port) else $error("port number wrong");
   property p_speed; rd |-> prdata[3:0] == link_speed; endproperty
   a_speed: assert property (p_speed) else $error("speed output differs");
   // Invalid codes fall back to one lane, valid ones are clamped to the strap
   property p_width; rd |-> train_width == (!(wf inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20}) ?
      6'h01 : (wf < phys_width_pin ? wf : phys_width_pin)); endproperty
   a_width: assert property (p_width) else $error("training width wrong");
   property p_up; rd && upstream_pin |-> prdata[21:20] == 2'h0; endproperty
   a_up: assert property (p_up) else $error("upstream bits set");
   property p_cc; acc && pwrite && paddr == 12'h080 |=> common_clock == $past(pwdata[0]); endproperty
   a_cc: assert property (p_cc) else $error("common clock not taken");
   property p_err; acc |-> pslverr == !(paddr == 12'h04C || paddr == 12'h080); endproperty
   a_err: assert property (p_err) else $error("error response wrong");
   property p_init; $rose(rst_n) |-> !pready [*2]; endproperty
   a_init: assert property (p_init) else $error("ready during init");
   c_up: cover property (rd && upstream_pin);
   c_cc: cover property (rd && common_clock);
   c_err: cover property (acc && pslverr);
endmodule : lcr_link_cap_properties

bind lcr_link_cap lcr_link_cap_properties u_props (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .upstream_pin, .legacy_rev_pin, .phys_width_pin, .port_num_pin, .link_speed,
   .train_width, .common_clock);

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
   import lcr_pkg::*;
   logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [15:0] strap = 16'h0405;
   logic [5:0]  train_width;
   logic [3:0]  link_speed;
   logic        common_clock;
   int          err_total = 0, n_checks = 0, cyc = 0;
   logic [5:0]  wc [7] = '{6'h00, 6'h03, 6'h3F, 6'h01, 6'h02, 6'h04, 6'h08};
   logic [5:0]  we [7] = '{6'h01, 6'h01, 6'h01, 6'h01, 6'h02, 6'h04, 6'h04};
   always #2.5 ref_clk = ~ref_clk;
   lcr_link_cap uut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .upstream_pin(strap[15]), .legacy_rev_pin(strap[14]), .phys_width_pin(strap[13:8]),
      .port_num_pin(strap[7:0]), .link_speed, .train_width, .common_clock);
   // Capabilities word expected from straps and the common clock bit
   function automatic logic [31:0] cap(logic u, logic l, logic [5:0] w, logic [7:0] n, logic c);
      return {n, 2'h0, ~u & ~l, ~u, ~u, 1'h0, 3'h2, c ? 3'h3 : 3'h5, 2'h3, w, 4'h1};
   endfunction : cap
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, s, x);
      end
   endtask : check
   // Waits for ready without assuming a latency; the timeout cuts a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic er);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Straps settle before release and stay put afterwards
   task automatic boot(input logic [15:0] s);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      strap <= s;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
   endtask : boot
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   // Cycle ceiling well above the 120 or so cycles the tests need
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      boot(16'h0405);
      apb(1'b0, 12'h04C, 32'h0, q, e);
      check(q, cap(0, 0, 6'h04, 8'h05, 0));
      apb(1'b0, 12'h080, 32'h0, q, e);
      check(q, 32'h0);
      apb(1'b1, 12'h04C, 32'hFFFFFFFF, q, e);
      apb(1'b0, 12'h04C, 32'h0, q, e);
      check(q, cap(0, 0, 6'h04, 8'h05, 0));
      $display("test defaults and lock done");
      apb(1'b1, 12'h080, 32'h3, q, e);
      apb(1'b0, 12'h080, 32'h0, q, e);
      check(q, 32'h3);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 12'h04C, cap(0, 0, wc[i], 8'h05, 0), q, e);
         apb(1'b0, 12'h04C, 32'h0, q, e);
         check(q, cap(0, 0, wc[i], 8'h05, 1));
         check(train_width, we[i]);
      end
      check(common_clock, 1'b1);
      apb(1'b0, 12'h100, 32'h0, q, e);
      check({31'h0, e}, 32'h1);
      check(q, 32'h0);
      $display("test width, clock and unmapped done");
      boot(16'h8800);
      apb(1'b0, 12'h04C, 32'h0, q, e);
      check(q, cap(1, 0, 6'h08, 8'h00, 0));
      apb(1'b1, 12'h080, 32'h2, q, e);
      apb(1'b1, 12'h04C, 32'hFFFFFFFF, q, e);
      apb(1'b0, 12'h04C, 32'h0, q, e);
      check(q, 32'h000FDFFF);
      check(train_width, 6'h01);
      check(link_speed, 4'hF);
      boot(16'h4102);
      apb(1'b0, 12'h04C, 32'h0, q, e);
      check(q, cap(0, 1, 6'h01, 8'h02, 0));
      $display("test upstream and older mode done");
      end_sim();
   end
endmodule : tb
